/* File: rtl/acpc_top.sv */
`timescale 1ns/1ps
// How it works
// R1 - After reset the converter is powered down and idle until a request.
// R2 - Each conversion wakes the converter, then shuts it down on completion.
// R3 - Start by convert_start_n pulse, cycle-interval tick, or command write-address phase.
// R4 - Bus transactions proceed in shutdown without any wake-up.
// R5 - Result is straight binary, stepping one code per LSB.
// R6 - Result width is 10 or 12 bits by variant.
// R7 - About 1 us wake-up then about 2 us conversion, then shutdown.
// R8 - Track while idle; hold the sample for the whole conversion.
// R9 - SAR logic trims the trial code bit by bit, then completes.
// R10 - Basic variant does standard and fast; high-speed variant adds high-speed.
// R11 - Bus address follows the address-select strap: high, low or floating.
// R12 - Floating gives 0100000; low on basic variant gives 0100001.
// R13 - The result register updates on completion before shutdown.
module acpc_top #(
  parameter int RES_W = 12,
  parameter bit HS_VARIANT = 1'b0,
  parameter int WAKE_CYC = acpc_pkg::WAKE_CYCLES,
  parameter int CONV_CYC = acpc_pkg::CONV_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Conversion triggers.
  input wire logic convert_start_n_i,
  input wire logic cycle_tick_i,
  input wire logic cmd_addr_wr_i,
  // Bus side.
  input wire logic [1:0] bus_address_select_i,
  input wire logic hs_mode_req_i,
  input wire logic bus_active_i,
  // Analog front end.
  input wire logic cmp_hi_i,
  output logic power_up_o,
  output logic track_o,
  output logic [RES_W-1:0] dac_code_o,
  // Status and result.
  output logic busy_o,
  output logic result_valid_o,
  output logic [RES_W-1:0] result_o,
  output logic [6:0] bus_addr_o,
  output logic hs_allowed_o,
  output logic bus_ready_o
);
  acpc_pkg::acpc_state_t state_r, state_nxt;
  logic [acpc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic cs_prev_r;
  logic power_r, track_r, busy_r, valid_r, hs_r, rdy_r;
  logic [RES_W-1:0] result_r;
  logic [6:0] addr_r;
  logic sar_start_r;
  logic [RES_W-1:0] sar_trial;
  logic sar_done;

  // A falling edge on the start pin is one request; holding it low does not retrigger.
  wire logic cs_fall = cs_prev_r & ~convert_start_n_i;
  wire logic start_req = cs_fall | cycle_tick_i | cmd_addr_wr_i; // R3
  wire logic wake_end = (cnt_r == acpc_pkg::CNT_W'(WAKE_CYC - 1));
  // SAR completion is latched so the timer may finish later.
  logic sar_fin_r;
  wire logic sar_finished = sar_fin_r | sar_done;
  wire logic conv_end = (cnt_r >= acpc_pkg::CNT_W'(CONV_CYC - 1)) && sar_finished;

  function automatic logic [6:0] acpc_addr(input logic [1:0] sel, input bit hs);
    if (sel == acpc_pkg::STRAP_FLOAT) return acpc_pkg::ADDR_FLOAT; // R12
    if (sel == acpc_pkg::STRAP_LOW) return hs ? acpc_pkg::ADDR_LOW_V1 : acpc_pkg::ADDR_LOW_V0;
    return hs ? acpc_pkg::ADDR_HIGH_V1 : acpc_pkg::ADDR_HIGH_V0;
  endfunction : acpc_addr

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 1'b1;
    unique case (state_r)
      acpc_pkg::ACPC_SHUTDOWN: begin
        cnt_nxt = '0;
        if (start_req) state_nxt = acpc_pkg::ACPC_WAKE; // R2
      end
      acpc_pkg::ACPC_WAKE: begin
        if (wake_end) begin // R7
          state_nxt = acpc_pkg::ACPC_CONVERT;
          cnt_nxt = '0;
        end
      end
      acpc_pkg::ACPC_CONVERT: begin
        if (cnt_r >= acpc_pkg::CNT_W'(CONV_CYC - 1)) cnt_nxt = cnt_r;
        if (conv_end) state_nxt = acpc_pkg::ACPC_DONE; // R7
      end
      acpc_pkg::ACPC_DONE: begin
        state_nxt = acpc_pkg::ACPC_SHUTDOWN; // R2
        cnt_nxt = '0;
      end
      default: begin
        state_nxt = acpc_pkg::ACPC_SHUTDOWN;
        cnt_nxt = '0;
      end
    endcase
  end

  // The SAR runs only about a dozen cycles; the timer stretches the phase to the nominal 2 us.
  acpc_sar #(.RES_W(RES_W)) u_sar (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .start_i(sar_start_r),
    .cmp_hi_i(cmp_hi_i),
    .trial_o(sar_trial),
    .done_o(sar_done)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= acpc_pkg::ACPC_SHUTDOWN; // R1
      cnt_r <= '0;
      cs_prev_r <= 1'b1;
      sar_start_r <= 1'b0;
      sar_fin_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cs_prev_r <= convert_start_n_i;
      sar_start_r <= (state_r == acpc_pkg::ACPC_WAKE) && wake_end;
      sar_fin_r <= (state_r == acpc_pkg::ACPC_CONVERT) && sar_finished;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_r <= 1'b0; // R1
      track_r <= 1'b1;
      busy_r <= 1'b0;
      valid_r <= 1'b0;
      result_r <= '0;
      addr_r <= acpc_pkg::ADDR_FLOAT;
      hs_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      // Power stays up through the done cycle so the result lands before shutdown.
      power_r <= (state_nxt != acpc_pkg::ACPC_SHUTDOWN); // R2
      track_r <= (state_nxt != acpc_pkg::ACPC_CONVERT); // R8
      busy_r <= (state_nxt != acpc_pkg::ACPC_SHUTDOWN);
      valid_r <= 1'b0;
      if (state_r == acpc_pkg::ACPC_CONVERT && conv_end) begin
        result_r <= sar_trial; // R13 R5 R6
        valid_r <= 1'b1;
      end
      addr_r <= acpc_addr(bus_address_select_i, HS_VARIANT); // R11
      hs_r <= HS_VARIANT & hs_mode_req_i; // R10
      rdy_r <= 1'b1; // R4
    end
  end

  // The strap is re-sampled continuously, so it should be static while bus_active_i is high.
  assign power_up_o = power_r;
  assign track_o = track_r;
  // The trial code is shown live, so the comparator judges the bit now being tried.
  assign dac_code_o = sar_trial; // R9
  assign busy_o = busy_r;
  assign result_valid_o = valid_r;
  assign result_o = result_r;
  assign bus_addr_o = addr_r;
  assign hs_allowed_o = hs_r;
  assign bus_ready_o = rdy_r;

  wire logic unused_ok = bus_active_i | sar_fin_r;

  property p_pwr_idle;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == acpc_pkg::ACPC_SHUTDOWN && !start_req) |=> !power_up_o;
  endproperty
  a_pwr_idle: assert property (p_pwr_idle) else $error("Powered without a request."); // R1

  sequence s_wake;
    state_r == acpc_pkg::ACPC_WAKE ##1 state_r == acpc_pkg::ACPC_WAKE;
  endsequence
  property p_start_wakes;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == acpc_pkg::ACPC_SHUTDOWN && start_req) |=> s_wake;
  endproperty
  a_start_wakes: assert property (p_start_wakes) else $error("Request did not wake."); // R3

  property p_done_off;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == acpc_pkg::ACPC_DONE) |=> (!power_up_o && state_r == acpc_pkg::ACPC_SHUTDOWN);
  endproperty
  a_done_off: assert property (p_done_off) else $error("No shutdown after convert."); // R2

  property p_track_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == acpc_pkg::ACPC_CONVERT) |-> !track_o;
  endproperty
  a_track_hold: assert property (p_track_hold) else $error("Tracking while converting."); // R8

  property p_result;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      result_valid_o |-> (result_o == $past(sar_trial) && state_r == acpc_pkg::ACPC_DONE);
  endproperty
  a_result: assert property (p_result) else $error("Result not updated at end."); // R13

  property p_wake_len;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(state_r == acpc_pkg::ACPC_CONVERT) |-> $past(cnt_r) == acpc_pkg::CNT_W'(WAKE_CYC - 1);
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("Wake time wrong."); // R7

  property p_addr_float;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (bus_address_select_i == acpc_pkg::STRAP_FLOAT) |=> bus_addr_o == 7'h20;
  endproperty
  a_addr_float: assert property (p_addr_float) else $error("Float address wrong."); // R12

  property p_hs;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      !HS_VARIANT |=> !hs_allowed_o;
  endproperty
  a_hs: assert property (p_hs) else $error("High speed on basic variant."); // R10

  property p_bus_rdy;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == acpc_pkg::ACPC_SHUTDOWN) ##1 1'b1 |-> bus_ready_o;
  endproperty
  a_bus_rdy: assert property (p_bus_rdy) else $error("Bus blocked in shutdown."); // R4
endmodule : acpc_top

/* File: rtl/acpc_pkg.sv */
package acpc_pkg;
  // Wake-up and conversion times, in nanoseconds.
  localparam int WAKE_TIME_NS = 1000;
  localparam int CONV_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 4;
  // Longest times round down, but never below one cycle.
  localparam int WAKE_CYCLES = (WAKE_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
                               : (WAKE_TIME_NS / CLK_PERIOD_NS);
  localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
                               : (CONV_TIME_NS / CLK_PERIOD_NS);
  localparam int CNT_W = 12;
  // Bus addresses by address-select strap.
  localparam logic [6:0] ADDR_FLOAT = 7'h20;
  localparam logic [6:0] ADDR_LOW_V0 = 7'h21;
  localparam logic [6:0] ADDR_HIGH_V0 = 7'h22;
  localparam logic [6:0] ADDR_LOW_V1 = 7'h23;
  localparam logic [6:0] ADDR_HIGH_V1 = 7'h24;
  // Strap encoding of the address-select pin.
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;
  localparam int RES_W_MAX = 12;
  typedef enum logic [2:0] {ACPC_SHUTDOWN, ACPC_WAKE, ACPC_CONVERT, ACPC_DONE} acpc_state_t;
endpackage : acpc_pkg

/* File: rtl/acpc_sar.sv */
`timescale 1ns/1ps
module acpc_sar #(
  parameter int RES_W = 12
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Control.
  input wire logic start_i,
  input wire logic cmp_hi_i,
  // Result.
  output logic [RES_W-1:0] trial_o,
  output logic done_o
);
  logic [RES_W-1:0] trial_r;
  logic [RES_W-1:0] mask_r;
  logic busy_r;
  logic done_r;
  wire logic [RES_W-1:0] kept = cmp_hi_i ? (trial_r & ~mask_r) : trial_r;
  wire logic [RES_W-1:0] mask_nxt = mask_r >> 1;

  // One bit is resolved per step, from the MSB down; comparator high means trial above input.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trial_r <= '0;
      mask_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start_i) begin
        mask_r <= {1'b1, {(RES_W-1){1'b0}}};
        trial_r <= {1'b1, {(RES_W-1){1'b0}}};
        busy_r <= 1'b1;
      end else if (busy_r) begin // R9
        trial_r <= kept | mask_nxt;
        mask_r <= mask_nxt;
        if (mask_nxt == '0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign trial_o = trial_r;
  assign done_o = done_r;
endmodule : acpc_sar

/* File: dv/acpc_cmp_model.sv */
`timescale 1ns/1ps
module acpc_cmp_model (
  // Clock.
  input wire logic ref_clk_i,
  // Front-end controls from the block, and the analog input.
  input wire logic track_i,
  input wire logic [11:0] dac_code_i,
  input wire logic [11:0] vin_i,
  // Comparator verdict.
  output logic cmp_hi_o
);
  logic [11:0] held_r;
  // The sample follows the input only while tracking, so a late input change cannot leak in.
  always_ff @(posedge ref_clk_i) begin
    if (track_i) begin
      held_r <= vin_i;
    end
  end
  // Code transitions sit at whole LSB steps of the held input.
  assign cmp_hi_o = dac_code_i > held_r;
endmodule : acpc_cmp_model

/* File: dv/acpc_top_tb.sv */
`timescale 1ns/1ps
module acpc_top_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic convert_start_n_i = 1'b1;
  logic cycle_tick_i = 1'b0;
  logic cmd_addr_wr_i = 1'b0;
  logic [1:0] bus_address_select_i = 2'h2;
  logic hs_mode_req_i = 1'b0;
  logic bus_active_i = 1'b0;
  logic cmp_hi_i;
  logic power_up_o, track_o, busy_o, result_valid_o, hs_allowed_o, bus_ready_o;
  logic [11:0] dac_code_o, result_o;
  logic [11:0] vin = 12'h000;
  logic [6:0] bus_addr_o;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 ref_clk_i = ~ref_clk_i;

  acpc_top #(.RES_W(12), .HS_VARIANT(1'b0), .WAKE_CYC(4), .CONV_CYC(20)) i_acpc_top (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .convert_start_n_i(convert_start_n_i),
    .cycle_tick_i(cycle_tick_i), .cmd_addr_wr_i(cmd_addr_wr_i),
    .bus_address_select_i(bus_address_select_i), .hs_mode_req_i(hs_mode_req_i),
    .bus_active_i(bus_active_i), .cmp_hi_i(cmp_hi_i), .power_up_o(power_up_o),
    .track_o(track_o), .dac_code_o(dac_code_o), .busy_o(busy_o),
    .result_valid_o(result_valid_o), .result_o(result_o), .bus_addr_o(bus_addr_o),
    .hs_allowed_o(hs_allowed_o), .bus_ready_o(bus_ready_o));

  acpc_cmp_model i_acpc_cmp_model (
    .ref_clk_i(ref_clk_i), .track_i(track_o), .dac_code_i(dac_code_o), .vin_i(vin),
    .cmp_hi_o(cmp_hi_i));

  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // A hung handshake would otherwise stall the run forever.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  function automatic logic [6:0] addr_exp(input logic [1:0] strap);
    if (strap == 2'h2) return 7'h20;
    return (strap == 2'h0) ? 7'h21 : 7'h22;
  endfunction : addr_exp

  task automatic convert(input int trig, input logic [11:0] v);
    int t;
    @(negedge ref_clk_i);
    vin = v;
    @(negedge ref_clk_i);
    case (trig)
      0: convert_start_n_i = 1'b0;
      1: cycle_tick_i = 1'b1;
      default: cmd_addr_wr_i = 1'b1;
    endcase
    @(negedge ref_clk_i);
    convert_start_n_i = 1'b1;
    cycle_tick_i = 1'b0;
    cmd_addr_wr_i = 1'b0;
    t = 0;
    while (power_up_o !== 1'b1 && t < 4) begin
      @(negedge ref_clk_i);
      t++;
    end
    check(power_up_o, 1, "no wake-up");
    check(busy_o, 1, "not busy");
    t = 0;
    while (track_o !== 1'b0 && t < 20) begin
      @(negedge ref_clk_i);
      t++;
    end
    check(track_o, 0, "still tracking");
    check(t >= 3, 1, "wake-up too short");
    // A new input and a second request while busy must both be ignored.
    vin = 12'($urandom);
    cmd_addr_wr_i = 1'b1;
    @(negedge ref_clk_i);
    cmd_addr_wr_i = 1'b0;
    t = 0;
    while (result_valid_o !== 1'b1 && t < 200) begin
      @(negedge ref_clk_i);
      t++;
    end
    check(t >= 11, 1, "conversion too short");
    check(result_o, v, "result code");
    check(power_up_o, 1, "result after shutdown");
    check(bus_ready_o, 1, "bus blocked");
    @(negedge ref_clk_i);
    check({power_up_o, busy_o, track_o}, 3'h1, "no shutdown");
    repeat (8) @(negedge ref_clk_i);
    check(power_up_o, 0, "refused request ran");
    check(result_o, v, "result lost");
  endtask : convert

  initial begin
    void'($urandom(32'h46ecb5d9));
    repeat (6) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    check({power_up_o, busy_o, track_o}, 3'h1, "not powered down");
    check(bus_ready_o, 1, "bus not ready");
    for (int s = 0; s < 4; s++) begin
      bus_address_select_i = 2'(s);
      hs_mode_req_i = s[0];
      repeat (2) @(negedge ref_clk_i);
      check(bus_addr_o, addr_exp(2'(s)), "bus address");
      check(hs_allowed_o, 0, "high speed on basic");
    end
    convert(0, 12'h000);
    convert(1, 12'hFFF);
    convert(2, 12'hAAA);
    for (int k = 0; k < 12; k++) begin
      convert(k % 3, 12'($urandom));
    end
    wrap_up();
  end
endmodule : acpc_top_tb
